// file: common/mad_defines.svh
`ifndef MAD_DEFINES_SVH
`define MAD_DEFINES_SVH

// ****************************************************************
// register file map
// ****************************************************************
`define MAD_RF_AW        12
`define MAD_RF_BYTES     4096
`define MAD_RAM_BASE     12'h000
`define MAD_RAM_BYTES    1024
`define MAD_CTL_BASE     12'hf00
`define MAD_CTL_LAST     12'hfff
`define MAD_FPS_ADDR     12'hff0
`define MAD_FPS_INFO_BIT 7
`define MAD_FPS_RESET    8'h00
`define MAD_UNDEF_BYTE   8'h00

// ****************************************************************
// program space map
// ****************************************************************
`define MAD_PM_AW        16
`define MAD_FLASH_BYTES  4096
`define MAD_UNIMPL_BYTE  8'hff
`define MAD_OPT_LAST     16'h0001
`define MAD_RST_LAST     16'h0003
`define MAD_WDT_LAST     16'h0005
`define MAD_TRAP_LAST    16'h0007
`define MAD_IRQ_LAST     16'h0037
`define MAD_RSV_LAST     16'h0039
`define MAD_OSC_LAST     16'h003d
`define MAD_CODE_FIRST   16'h003e

// ****************************************************************
// information area
// ****************************************************************
`define MAD_INFO_BASE    16'hfe00
`define MAD_INFO_LAST    16'hff7f
`define MAD_INFO_AW      7
`define MAD_INFO_BYTES   128
`define MAD_PN_FIRST     7'h40
`define MAD_PN_LAST      7'h53
`define MAD_IRSV_LAST    7'h5f
`define MAD_PN_CHARS     20

`endif

// file: common/mad_info_if.sv
`timescale 1ns/100ps
`include "mad_defines.svh"

interface mad_info_if;
  logic [`MAD_INFO_AW-1:0] idx;
  logic [7:0]              data;
  modport reader (output idx, input data);
  modport rom    (input idx, output data);
endinterface

// file: common/mad_pkg.sv
`include "mad_defines.svh"

package mad_pkg;

  typedef enum logic [3:0] {
    MAD_RG_OPTION = 4'h0,
    MAD_RG_RESET  = 4'h1,
    MAD_RG_WDT    = 4'h3,
    MAD_RG_TRAP   = 4'h2,
    MAD_RG_IRQ    = 4'h6,
    MAD_RG_RSVD   = 4'h7,
    MAD_RG_OSC    = 4'h5,
    MAD_RG_CODE   = 4'h4,
    MAD_RG_INFO   = 4'hc,
    MAD_RG_UNIMPL = 4'hd
  } mad_region_t;

  typedef struct packed {
    logic [`MAD_RAM_BYTES-1:0][7:0]   ram;
    logic [`MAD_FLASH_BYTES-1:0][7:0] flash;
    logic [7:0]                       fps;
    logic                             rf_ack;
    logic [7:0]                       rf_rdata;
    logic                             pm_ack;
    logic [7:0]                       pm_rdata;
    mad_region_t                      pm_region;
    logic                             dm_miss;
    logic                             ctl_wr;
    logic [7:0]                       ctl_addr;
    logic [7:0]                       ctl_wdata;
  } mad_state_t;

endpackage

// file: core/mad_decoder.sv
`timescale 1ns/100ps
`include "mad_defines.svh"

// Functional notes
// - decode 4096-byte register file, two sections
// - control registers occupy F00H through FFFH
// - unassigned control reads undefined; avoid writing
// - on-chip RAM starts at register 000H
// - gap above RAM: undefined reads, writes ignored
// - 64 KB program space, flash, code from 003EH
// - unimplemented program reads FFH, writes ignored
// - option bits, reset, watchdog, trap vectors
// - interrupt vectors, reserved, oscillator-fail vectors
// - data-only memory space not implemented
// - page select bit 7 enables information overlay
// - overlay serves FE00H through FF7FH reads
// - information area is read-only
// - 20-character part identifier, ff padded
// - calibration data and reserved information bytes

module mad_decoder
  import mad_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  input  wire logic                   rf_req,
  input  wire logic                   rf_we,
  input  wire logic [`MAD_RF_AW-1:0]  rf_addr,
  input  wire logic [7:0]             rf_wdata,
  output logic                        rf_ack_q,
  output logic [7:0]                  rf_rdata_q,
  input  wire logic                   pm_req,
  input  wire logic                   pm_we,
  input  wire logic [`MAD_PM_AW-1:0]  pm_addr,
  input  wire logic [7:0]             pm_wdata,
  output logic                        pm_ack_q,
  output logic [7:0]                  pm_rdata_q,
  output mad_region_t                 pm_region_q,
  input  wire logic                   dm_req,
  output logic                        dm_miss_q,
  output logic                        info_en_q,
  output logic                        ctl_wr_q,
  output logic [7:0]                  ctl_addr_q,
  output logic [7:0]                  ctl_wdata_q
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_q[1];

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic mad_region_t pm_region_f(input logic [`MAD_PM_AW-1:0] a,
                                              input logic                  ov);
    if (ov && a >= `MAD_INFO_BASE && a <= `MAD_INFO_LAST) begin
      pm_region_f = MAD_RG_INFO;
    end else if (a >= `MAD_PM_AW'(`MAD_FLASH_BYTES)) begin
      pm_region_f = MAD_RG_UNIMPL;
    end else if (a <= `MAD_OPT_LAST) begin
      pm_region_f = MAD_RG_OPTION;
    end else if (a <= `MAD_RST_LAST) begin
      pm_region_f = MAD_RG_RESET;
    end else if (a <= `MAD_WDT_LAST) begin
      pm_region_f = MAD_RG_WDT;
    end else if (a <= `MAD_TRAP_LAST) begin
      pm_region_f = MAD_RG_TRAP;
    end else if (a <= `MAD_IRQ_LAST) begin
      pm_region_f = MAD_RG_IRQ;
    end else if (a <= `MAD_RSV_LAST) begin
      pm_region_f = MAD_RG_RSVD;
    end else if (a <= `MAD_OSC_LAST) begin
      pm_region_f = MAD_RG_OSC;
    end else begin
      pm_region_f = MAD_RG_CODE;
    end
  endfunction

  function automatic logic in_ram_f(input logic [`MAD_RF_AW-1:0] a);
    in_ram_f = a < `MAD_RF_AW'(`MAD_RAM_BYTES);
  endfunction

  // ****************************************************************
  // information area lookup
  // ****************************************************************
  mad_info_if info_bus ();

  assign info_bus.idx = pm_addr[`MAD_INFO_AW-1:0];

  mad_info_rom u_info_rom (
    .info (info_bus.rom)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  mad_state_t  s_q;
  mad_state_t  s_d;
  mad_region_t reg_now;

  assign reg_now = pm_region_f(pm_addr, s_q.fps[`MAD_FPS_INFO_BIT]);

  always_comb begin
    s_d        = s_q;
    s_d.rf_ack = 1'b0;
    s_d.pm_ack = 1'b0;
    s_d.ctl_wr = 1'b0;
    s_d.dm_miss = dm_req;
    if (rf_req) begin
      s_d.rf_ack = 1'b1;
      if (rf_addr >= `MAD_CTL_BASE) begin
        if (rf_addr == `MAD_FPS_ADDR) begin
          s_d.rf_rdata = s_q.fps;
          if (rf_we) begin
            s_d.fps = rf_wdata;
          end
        end else begin
          // peripheral read data is not routed through this block
          s_d.rf_rdata = `MAD_UNDEF_BYTE;
          if (rf_we) begin
            s_d.ctl_wr    = 1'b1;
            s_d.ctl_addr  = rf_addr[7:0];
            s_d.ctl_wdata = rf_wdata;
          end
        end
      end else if (in_ram_f(rf_addr)) begin
        s_d.rf_rdata = s_q.ram[rf_addr[9:0]];
        if (rf_we) begin
          s_d.ram[rf_addr[9:0]] = rf_wdata;
        end
      end else begin
        s_d.rf_rdata = `MAD_UNDEF_BYTE;
      end
    end
    if (pm_req) begin
      s_d.pm_ack    = 1'b1;
      s_d.pm_region = reg_now;
      case (reg_now)
        MAD_RG_INFO: begin
          // only the low 128 bytes of the overlay hold data, the rest reads as reserved
          if (pm_addr < `MAD_INFO_BASE + `MAD_PM_AW'(`MAD_INFO_BYTES)) begin
            s_d.pm_rdata = info_bus.data;
          end else begin
            s_d.pm_rdata = `MAD_UNIMPL_BYTE;
          end
        end
        MAD_RG_UNIMPL: begin
          s_d.pm_rdata = `MAD_UNIMPL_BYTE;
        end
        default: begin
          s_d.pm_rdata = s_q.flash[pm_addr[11:0]];
          if (pm_we) begin
            s_d.flash[pm_addr[11:0]] = pm_wdata;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q           <= '0;
      s_q.flash     <= '1;
      s_q.fps       <= `MAD_FPS_RESET;
      s_q.pm_region <= MAD_RG_OPTION;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign rf_ack_q    = s_q.rf_ack;
  assign rf_rdata_q  = s_q.rf_rdata;
  assign pm_ack_q    = s_q.pm_ack;
  assign pm_rdata_q  = s_q.pm_rdata;
  assign pm_region_q = s_q.pm_region;
  assign dm_miss_q   = s_q.dm_miss;
  assign info_en_q   = s_q.fps[`MAD_FPS_INFO_BIT];
  assign ctl_wr_q    = s_q.ctl_wr;
  assign ctl_addr_q  = s_q.ctl_addr;
  assign ctl_wdata_q = s_q.ctl_wdata;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_rf_ack;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    clk_en && rf_req |=> rf_ack_q;
  endproperty
  a_rf_ack: assert property (p_rf_ack) else $error("register access not acknowledged");

  property p_ctl_fwd;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    clk_en && rf_req && rf_we && rf_addr >= `MAD_CTL_BASE && rf_addr != `MAD_FPS_ADDR
      |=> ctl_wr_q && ctl_addr_q == $past(rf_addr[7:0]) && ctl_wdata_q == $past(rf_wdata);
  endproperty
  a_ctl_fwd: assert property (p_ctl_fwd) else $error("control write not forwarded");

  property p_ram_rw;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    (clk_en && rf_req && rf_we && in_ram_f(rf_addr)) ##1 (clk_en && !rf_req) ##1
    (clk_en && rf_req && !rf_we && rf_addr == $past(rf_addr, 2))
      |=> rf_rdata_q == $past(rf_wdata, 3);
  endproperty
  a_ram_rw: assert property (p_ram_rw) else $error("ram read back mismatch");

  property p_gap;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    clk_en && rf_req && !in_ram_f(rf_addr) && rf_addr < `MAD_CTL_BASE
      |=> rf_ack_q && rf_rdata_q == `MAD_UNDEF_BYTE;
  endproperty
  a_gap: assert property (p_gap) else $error("gap read not undefined value");

  property p_unimpl;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    clk_en && pm_req && pm_addr >= `MAD_PM_AW'(`MAD_FLASH_BYTES) && !info_en_q
      |=> pm_ack_q && pm_rdata_q == `MAD_UNIMPL_BYTE && pm_region_q == MAD_RG_UNIMPL;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented read not ff");

  property p_vec;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    clk_en && pm_req && pm_addr >= 16'h0002 && pm_addr <= `MAD_RST_LAST
      |=> pm_region_q == MAD_RG_RESET;
  endproperty
  a_vec: assert property (p_vec) else $error("reset vector misdecoded");

  property p_osc;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    clk_en && pm_req && pm_addr >= 16'h003a && pm_addr <= `MAD_OSC_LAST
      |=> pm_region_q == MAD_RG_OSC;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator vector misdecoded");

  property p_dm;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    clk_en && dm_req && !rf_req |=> dm_miss_q && !rf_ack_q;
  endproperty
  a_dm: assert property (p_dm) else $error("data space answered");

  property p_fps;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    clk_en && rf_req && rf_we && rf_addr == `MAD_FPS_ADDR
      |=> info_en_q == $past(rf_wdata[`MAD_FPS_INFO_BIT]);
  endproperty
  a_fps: assert property (p_fps) else $error("overlay enable not taken");

  property p_info_rsv;
    @(posedge ref_clk) disable iff (!rst_sync_n)
    clk_en && pm_req && info_en_q && pm_addr >= 16'hfe54 && pm_addr <= 16'hfe5f
      |=> pm_region_q == MAD_RG_INFO && pm_rdata_q == `MAD_UNIMPL_BYTE;
  endproperty
  a_info_rsv: assert property (p_info_rsv) else $error("info reserved not ff");

  property p_rst;
    @(posedge ref_clk)
    $rose(rst_sync_n) |-> !info_en_q;
  endproperty
  a_rst: assert property (p_rst) else $error("overlay enabled after reset");

endmodule

// file: core/mad_info_rom.sv
`timescale 1ns/100ps
`include "mad_defines.svh"

module mad_info_rom
  import mad_pkg::*;
#(
  // arbitrary identifier, left aligned, padded with ff
  parameter logic [8*`MAD_PN_CHARS-1:0] PART_ID  = {"MAD-DEMO-0", {10{8'hff}}},
  // arbitrary calibration pattern seed
  parameter logic [7:0]                 CAL_SEED = 8'h5a
) (
  mad_info_if.rom info
);

  function automatic logic [7:0] info_byte_f(input logic [`MAD_INFO_AW-1:0] i);
    logic [`MAD_INFO_AW-1:0] k;
    k = i - `MAD_PN_FIRST;
    if (i < `MAD_PN_FIRST) begin
      info_byte_f = CAL_SEED ^ {1'b0, i};
    end else if (i <= `MAD_PN_LAST) begin
      info_byte_f = PART_ID[8*`MAD_PN_CHARS-1-8*k -: 8];
    end else if (i <= `MAD_IRSV_LAST) begin
      info_byte_f = `MAD_UNIMPL_BYTE;
    end else begin
      info_byte_f = ~CAL_SEED ^ {1'b0, i};
    end
  endfunction

  assign info.data = info_byte_f(info.idx);

endmodule

// file: verification/mad_core_model.sv
`timescale 1ns/100ps

// ****************************************************************
// processor core model: one byte access at a time
// ****************************************************************
module mad_core_model (
  input  wire logic        ref_clk,
  output logic             rf_req,
  output logic             rf_we,
  output logic [11:0]      rf_addr,
  output logic [7:0]       rf_wdata,
  input  wire logic        rf_ack_q,
  input  wire logic [7:0]  rf_rdata_q,
  output logic             pm_req,
  output logic             pm_we,
  output logic [15:0]      pm_addr,
  output logic [7:0]       pm_wdata,
  input  wire logic        pm_ack_q,
  input  wire logic [7:0]  pm_rdata_q,
  output logic             dm_req,
  input  wire logic        dm_miss_q
);
  initial begin
    {rf_req, rf_we, pm_req, pm_we, dm_req} = 5'h00;
    {rf_addr, rf_wdata, pm_addr, pm_wdata} = 44'h0;
  end

  // pm selects the program bus, otherwise the register file bus
  task automatic acc(input logic pm, input logic we, input logic [15:0] a,
                     input logic [7:0] wd, output logic ack, output logic [7:0] rd);
    @(posedge ref_clk);
    rf_req   <= ~pm;
    pm_req   <= pm;
    rf_we    <= we;
    pm_we    <= we;
    rf_addr  <= a[11:0];
    pm_addr  <= a;
    rf_wdata <= wd;
    pm_wdata <= wd;
    @(posedge ref_clk);
    {rf_req, pm_req, rf_we, pm_we} <= 4'h0;
    // released lines show the inverse so a stale value cannot pass
    rf_addr  <= ~a[11:0];
    pm_addr  <= ~a;
    rf_wdata <= ~wd;
    pm_wdata <= ~wd;
    #1;
    ack = pm ? pm_ack_q : rf_ack_q;
    rd  = pm ? pm_rdata_q : rf_rdata_q;
  endtask

  task automatic dm_acc(output logic miss);
    @(posedge ref_clk);
    dm_req <= 1'b1;
    @(posedge ref_clk);
    dm_req <= 1'b0;
    #1;
    miss = dm_miss_q;
  endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/100ps
`include "mad_defines.svh"

module tb
  import mad_pkg::*;
;
  logic                   ref_clk;
  logic                   rst_n;
  logic                   clk_en;
  logic                   rf_req, rf_we, pm_req, pm_we, dm_req;
  logic                   rf_ack_q, pm_ack_q, dm_miss_q, info_en_q, ctl_wr_q;
  logic [`MAD_RF_AW-1:0]  rf_addr;
  logic [`MAD_PM_AW-1:0]  pm_addr;
  logic [7:0]             rf_wdata, pm_wdata, rf_rdata_q, pm_rdata_q;
  logic [7:0]             ctl_addr_q, ctl_wdata_q, rd;
  logic                   ack;
  mad_region_t            pm_region_q;
  int                     fail_count = 0;
  int                     comparisons = 0;
  int                     cycles = 0;
  logic [15:0]            map_a [15] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0005,
    16'h0006, 16'h0008, 16'h0037, 16'h0038, 16'h0039, 16'h003a, 16'h003d, 16'h003e,
    16'h0fff, 16'h1000};
  mad_region_t            map_r [15] = '{MAD_RG_OPTION, MAD_RG_OPTION, MAD_RG_RESET,
    MAD_RG_RESET, MAD_RG_WDT, MAD_RG_TRAP, MAD_RG_IRQ, MAD_RG_IRQ, MAD_RG_RSVD, MAD_RG_RSVD,
    MAD_RG_OSC, MAD_RG_OSC, MAD_RG_CODE, MAD_RG_CODE, MAD_RG_UNIMPL};
  logic [7:0]             inf_a [12] = '{8'h00, 8'h3f, 8'h40, 8'h49, 8'h4a, 8'h53, 8'h54,
    8'h5f, 8'h60, 8'h7f, 8'h80, 8'h7f};
  logic [7:0]             inf_d [12] = '{8'h5a, 8'h65, 8'h4d, 8'h30, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hc5, 8'hda, 8'hff, 8'hff};

  mad_decoder uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .rf_req(rf_req), .rf_we(rf_we), .rf_addr(rf_addr), .rf_wdata(rf_wdata),
    .rf_ack_q(rf_ack_q), .rf_rdata_q(rf_rdata_q), .pm_req(pm_req), .pm_we(pm_we),
    .pm_addr(pm_addr), .pm_wdata(pm_wdata), .pm_ack_q(pm_ack_q), .pm_rdata_q(pm_rdata_q),
    .pm_region_q(pm_region_q), .dm_req(dm_req), .dm_miss_q(dm_miss_q),
    .info_en_q(info_en_q), .ctl_wr_q(ctl_wr_q), .ctl_addr_q(ctl_addr_q),
    .ctl_wdata_q(ctl_wdata_q));

  mad_core_model core (.ref_clk(ref_clk), .rf_req(rf_req), .rf_we(rf_we),
    .rf_addr(rf_addr), .rf_wdata(rf_wdata), .rf_ack_q(rf_ack_q), .rf_rdata_q(rf_rdata_q),
    .pm_req(pm_req), .pm_we(pm_we), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
    .pm_ack_q(pm_ack_q), .pm_rdata_q(pm_rdata_q), .dm_req(dm_req), .dm_miss_q(dm_miss_q));

  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  // about 125 cycles are needed; the margin covers a stuck handshake
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end

  // ****************************************************************
  // compare and access helpers
  // ****************************************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic chk_reg(input mad_region_t got, input mad_region_t exp);
    chk8({4'h0, got}, {4'h0, exp}, "region");
  endtask

  task automatic rf_wr(input logic [11:0] a, input logic [7:0] d);
    core.acc(1'b0, 1'b1, {4'h0, a}, d, ack, rd);
    chk_bit(ack, 1'b1, "rf write ack");
  endtask

  task automatic rf_rd(input logic [11:0] a, input logic [7:0] exp);
    core.acc(1'b0, 1'b0, {4'h0, a}, 8'h00, ack, rd);
    chk_bit(ack, 1'b1, "rf read ack");
    chk8(rd, exp, "rf read data");
  endtask

  task automatic pm_wr(input logic [15:0] a, input logic [7:0] d);
    core.acc(1'b1, 1'b1, a, d, ack, rd);
    chk_bit(ack, 1'b1, "pm write ack");
  endtask

  task automatic pm_rd(input logic [15:0] a, input logic [7:0] exp, input mad_region_t r);
    core.acc(1'b1, 1'b0, a, 8'h00, ack, rd);
    chk_bit(ack, 1'b1, "pm read ack");
    chk8(rd, exp, "pm read data");
    chk_reg(pm_region_q, r);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    chk_bit(info_en_q, 1'b0, "overlay after reset");
    pm_rd(16'hfe00, 8'hff, MAD_RG_UNIMPL);
  endtask

  task automatic t_ram;
    rf_wr(12'h000, 8'h11);
    rf_wr(12'h3ff, 8'h22);
    rf_rd(12'h3ff, 8'h22);
    rf_wr(12'h400, 8'h33);
    rf_wr(12'heff, 8'h44);
    chk_bit(ctl_wr_q, 1'b0, "gap write forwarded");
    rf_rd(12'h000, 8'h11);
    rf_rd(12'h3ff, 8'h22);
    rf_rd(12'h400, 8'h00);
    rf_rd(12'heff, 8'h00);
  endtask

  // a frozen enable must swallow the request: no ack and no ram update
  task automatic t_hold;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    core.acc(1'b0, 1'b1, 16'h0000, 8'h99, ack, rd);
    chk_bit(ack, 1'b0, "ack while frozen");
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rf_rd(12'h000, 8'h11);
  endtask

  task automatic t_ctl;
    rf_wr(12'hf06, 8'h5c);
    chk_bit(ctl_wr_q, 1'b1, "ctl write");
    chk8(ctl_addr_q, 8'h06, "ctl addr");
    chk8(ctl_wdata_q, 8'h5c, "ctl data");
    rf_wr(12'hf00, 8'ha3);
    chk8(ctl_addr_q, 8'h00, "ctl base addr");
    rf_rd(12'hf10, 8'h00);
  endtask

  task automatic t_flash;
    for (int i = 0; i < 15; i++) begin
      pm_rd(map_a[i], 8'hff, map_r[i]);
    end
    pm_wr(16'h003e, 8'h3c);
    pm_wr(16'h0fff, 8'hc3);
    pm_wr(16'h1000, 8'h55);
    pm_rd(16'h003e, 8'h3c, MAD_RG_CODE);
    pm_rd(16'h0fff, 8'hc3, MAD_RG_CODE);
    pm_rd(16'h1000, 8'hff, MAD_RG_UNIMPL);
    pm_rd(16'hffff, 8'hff, MAD_RG_UNIMPL);
  endtask

  task automatic t_data;
    logic miss;
    core.dm_acc(miss);
    chk_bit(miss, 1'b1, "data space miss");
  endtask

  task automatic t_info;
    rf_wr(12'hff0, 8'h80);
    chk_bit(info_en_q, 1'b1, "overlay on");
    chk_bit(ctl_wr_q, 1'b0, "page select forwarded");
    rf_rd(12'hff0, 8'h80);
    for (int i = 0; i < 12; i++) begin
      pm_rd({(i == 11) ? 8'hff : 8'hfe, inf_a[i]}, inf_d[i], MAD_RG_INFO);
    end
    pm_rd(16'hff80, 8'hff, MAD_RG_UNIMPL);
    pm_wr(16'hfe00, 8'h00);
    pm_rd(16'hfe00, 8'h5a, MAD_RG_INFO);
    rf_wr(12'hff0, 8'h7f);
    chk_bit(info_en_q, 1'b0, "overlay off");
    pm_rd(16'hfe00, 8'hff, MAD_RG_UNIMPL);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    rst_n  = 1'b0;
    clk_en = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    // the synchroniser needs two edges before the first request
    repeat (3) @(posedge ref_clk);
    #1;
    t_reset();
    t_ram();
    t_hold();
    t_ctl();
    t_flash();
    t_data();
    t_info();
    finish_test();
  end
endmodule
